// File: pkg/ebtcr_pkg.sv
// constants for the three-channel 8-bit timer control registers
// Functional notes
// - channel 0/1 select: edges, fx, fx/4 to fx/1024
// - channel 2 select: edges, fx/2 to fx/2048
// - reset clears select and mode registers
// - run bit low clears counter and prescaler
// - mode bit picks clear-on-match or free PWM
// - preset pair clears or sets output flip-flop
// - preset pair always reads back as zero
// - clear mode: bit 1 enables output toggling
// - PWM mode: bit 1 picks active-low output
// - output enable bit gates timer onto pin
// - PWM output inactive while channel stopped
// - mode register takes bit and byte writes
// - direction bit zero drives pin, one releases
// - reset sets both direction registers to ones
// - match in clear mode restarts count, raises interrupt
// - enabled toggle inverts flip-flop on each match, except when a preset write lands in the same cycle
package ebtcr_pkg;
   localparam int          NUM_CH            = 3;
   localparam int          ADDR_W            = 16;
   localparam int          DATA_W            = 8;
   localparam int          PRE_W             = 11;
   localparam logic [15:0] ADDR_PORT3_LATCH  = 16'hFF03;
   localparam logic [15:0] ADDR_PORT7_LATCH  = 16'hFF07;
   localparam logic [15:0] ADDR_PORT3_DIR    = 16'hFF23;
   localparam logic [15:0] ADDR_PORT7_DIR    = 16'hFF27;
   localparam logic [15:0] ADDR_TMC0         = 16'hFF70;
   localparam logic [15:0] ADDR_TCL0         = 16'hFF71;
   localparam logic [15:0] ADDR_TMC1         = 16'hFF72;
   localparam logic [15:0] ADDR_TCL1         = 16'hFF74;
   localparam logic [15:0] ADDR_TMC2         = 16'hFF76;
   localparam logic [15:0] ADDR_TCL2         = 16'hFF77;
   localparam logic [15:0] ADDR_CMP0         = 16'hFF80;
   localparam logic [15:0] ADDR_CMP1         = 16'hFF81;
   localparam logic [15:0] ADDR_CMP2         = 16'hFF82;
   localparam logic [15:0] ADDR_CNT0         = 16'hFF84;
   localparam logic [15:0] ADDR_CNT1         = 16'hFF85;
   localparam logic [15:0] ADDR_CNT2         = 16'hFF86;
   localparam logic [15:0] ADDR_IRQ_STAT     = 16'hFF88;
   localparam logic [15:0] ADDR_IRQ_EN       = 16'hFF89;
   localparam int          TMC_RUN_BIT       = 7;
   localparam int          TMC_PWM_BIT       = 6;
   localparam int          TMC_PRESET_HI_BIT = 3;
   localparam int          TMC_PRESET_LO_BIT = 2;
   localparam int          TMC_POL_BIT       = 1;
   localparam int          TMC_OE_BIT        = 0;
   localparam logic [2:0]  SEL_EV_FALL       = 3'h0;
   localparam logic [2:0]  SEL_EV_RISE       = 3'h1;
   localparam logic [2:0]  SEL_LADDER_BASE   = 3'h2;
   localparam logic [3:0]  LADDER_ODD_CH2    = 4'h1;
   localparam int          CH_ODD_LADDER     = 2;
   localparam logic [1:0]  PRESET_LOW        = 2'h1;
   localparam logic [1:0]  PRESET_HIGH       = 2'h2;
   localparam logic [7:0]  TMC_RST           = 8'h00;
   localparam logic [2:0]  TCL_RST           = 3'h0;
   localparam logic [7:0]  CMP_RST           = 8'h00;
   localparam logic [7:0]  DIR_RST           = 8'hFF;
   localparam logic [7:0]  LATCH_RST         = 8'h00;
   localparam logic [7:0]  PORT3_FIXED_ONES  = 8'hE0;
   localparam logic [7:0]  PORT7_FIXED_ONES  = 8'hF0;
   localparam logic [7:0]  CNT_TOP           = 8'hFF;
   localparam int          TOUT0_PORT3_BIT   = 3;
   localparam int          TOUT1_PORT3_BIT   = 4;
   localparam int          TOUT2_PORT7_BIT   = 2;
endpackage : ebtcr_pkg

// File: core/ebtcr_core.sv
// register file, prescalers, counters and pin gating for three timer channels
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ebtcr_core
(
   input  wire logic        ref_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        clk_en_in,
   input  wire logic [15:0] reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_bit_wr_in,
   input  wire logic [2:0]  reg_bit_sel_in,
   input  wire logic        reg_rd_in,
   output logic      [7:0]  reg_rdata_out,
   input  wire logic [2:0]  event_input_in,
   output logic      [2:0]  timer_output_out,
   output logic      [7:0]  port3_pin_out,
   output logic      [7:0]  port3_pin_oe_out,
   output logic      [7:0]  port7_pin_out,
   output logic      [7:0]  port7_pin_oe_out,
   output logic             irq_out
);

   logic [2:0]  run_r;
   logic [2:0]  pwm_r;
   logic [2:0]  pol_r;
   logic [2:0]  oe_r;
   logic [2:0]  tcl_r [3];
   logic [7:0]  cmp_r [3];
   logic [7:0]  cnt_r [3];
   logic [10:0] pre_r [3];
   logic [2:0]  ff_r;
   logic [2:0]  act_r;
   logic [2:0]  ev_d_r;
   logic [2:0]  stat_r;
   logic [2:0]  irq_en_r;
   logic [7:0]  dir3_r;
   logic [7:0]  dir7_r;
   logic [7:0]  latch3_r;
   logic [7:0]  latch7_r;
   logic [7:0]  rdata_r;
   logic [7:0]  rd_mux;
   logic [7:0]  wval;
   logic [7:0]  stat_clr;
   logic        wr_any;
   logic [2:0]  tmc_wr;
   logic [2:0]  tick;
   logic [2:0]  match_evt;
   logic [2:0]  tout;

   function automatic logic [15:0] tmc_addr(input int ch);
      case (ch)
         0:       tmc_addr = ebtcr_pkg::ADDR_TMC0;
         1:       tmc_addr = ebtcr_pkg::ADDR_TMC1;
         default: tmc_addr = ebtcr_pkg::ADDR_TMC2;
      endcase
   endfunction : tmc_addr

   function automatic logic [15:0] tcl_addr(input int ch);
      case (ch)
         0:       tcl_addr = ebtcr_pkg::ADDR_TCL0;
         1:       tcl_addr = ebtcr_pkg::ADDR_TCL1;
         default: tcl_addr = ebtcr_pkg::ADDR_TCL2;
      endcase
   endfunction : tcl_addr

   function automatic logic [15:0] cmp_addr(input int ch);
      case (ch)
         0:       cmp_addr = ebtcr_pkg::ADDR_CMP0;
         1:       cmp_addr = ebtcr_pkg::ADDR_CMP1;
         default: cmp_addr = ebtcr_pkg::ADDR_CMP2;
      endcase
   endfunction : cmp_addr

   function automatic logic [15:0] cnt_addr(input int ch);
      case (ch)
         0:       cnt_addr = ebtcr_pkg::ADDR_CNT0;
         1:       cnt_addr = ebtcr_pkg::ADDR_CNT1;
         default: cnt_addr = ebtcr_pkg::ADDR_CNT2;
      endcase
   endfunction : cnt_addr

   // read multiplexer, also the old value for bit writes
   always_comb
   begin
      rd_mux = 8'h00;
      for (int i = 0; i < ebtcr_pkg::NUM_CH; i++)
      begin
         if (reg_addr_in == tmc_addr(i))
            rd_mux = {run_r[i], pwm_r[i], 4'h0, pol_r[i], oe_r[i]};
         if (reg_addr_in == tcl_addr(i))
            rd_mux = {5'h00, tcl_r[i]};
         if (reg_addr_in == cmp_addr(i))
            rd_mux = cmp_r[i];
         if (reg_addr_in == cnt_addr(i))
            rd_mux = cnt_r[i];
      end
      case (reg_addr_in)
         ebtcr_pkg::ADDR_PORT3_DIR:   rd_mux = dir3_r | ebtcr_pkg::PORT3_FIXED_ONES;
         ebtcr_pkg::ADDR_PORT7_DIR:   rd_mux = dir7_r | ebtcr_pkg::PORT7_FIXED_ONES;
         ebtcr_pkg::ADDR_PORT3_LATCH: rd_mux = latch3_r;
         ebtcr_pkg::ADDR_PORT7_LATCH: rd_mux = latch7_r;
         ebtcr_pkg::ADDR_IRQ_STAT:    rd_mux = {5'h00, stat_r};
         ebtcr_pkg::ADDR_IRQ_EN:      rd_mux = {5'h00, irq_en_r};
         default:                     rd_mux = rd_mux;
      endcase
   end

   // bit writes merge one bit into the current value
   assign wr_any   = reg_wr_in | reg_bit_wr_in;
   assign wval     = reg_bit_wr_in ? ((rd_mux & ~(8'h01 << reg_bit_sel_in)) |
                                      ({7'h00, reg_wdata_in[0]} << reg_bit_sel_in)) : reg_wdata_in;
   assign stat_clr = reg_bit_wr_in ? ({7'h00, reg_wdata_in[0]} << reg_bit_sel_in) : reg_wdata_in;

   always_comb
   begin
      for (int i = 0; i < ebtcr_pkg::NUM_CH; i++)
         tmc_wr[i] = wr_any && (reg_addr_in == tmc_addr(i));
   end

   // mode, select and compare registers
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         run_r <= 3'h0;
         pwm_r <= 3'h0;
         pol_r <= 3'h0;
         oe_r  <= 3'h0;
         for (int i = 0; i < ebtcr_pkg::NUM_CH; i++)
         begin
            tcl_r[i] <= ebtcr_pkg::TCL_RST;
            cmp_r[i] <= ebtcr_pkg::CMP_RST;
         end
      end
      else if (clk_en_in)
      begin
         for (int i = 0; i < ebtcr_pkg::NUM_CH; i++)
         begin
            if (tmc_wr[i])
            begin
               run_r[i] <= wval[ebtcr_pkg::TMC_RUN_BIT];
               pwm_r[i] <= wval[ebtcr_pkg::TMC_PWM_BIT];
               pol_r[i] <= wval[ebtcr_pkg::TMC_POL_BIT];
               oe_r[i]  <= wval[ebtcr_pkg::TMC_OE_BIT];
            end
            if (wr_any && reg_addr_in == tcl_addr(i))
               tcl_r[i] <= wval[2:0];
            if (wr_any && reg_addr_in == cmp_addr(i))
               cmp_r[i] <= wval;
         end
      end
   end

   // port direction and latch registers
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         dir3_r   <= ebtcr_pkg::DIR_RST;
         dir7_r   <= ebtcr_pkg::DIR_RST;
         latch3_r <= ebtcr_pkg::LATCH_RST;
         latch7_r <= ebtcr_pkg::LATCH_RST;
      end
      else if (clk_en_in && wr_any)
      begin
         case (reg_addr_in)
            ebtcr_pkg::ADDR_PORT3_DIR:   dir3_r   <= wval | ebtcr_pkg::PORT3_FIXED_ONES;
            ebtcr_pkg::ADDR_PORT7_DIR:   dir7_r   <= wval | ebtcr_pkg::PORT7_FIXED_ONES;
            ebtcr_pkg::ADDR_PORT3_LATCH: latch3_r <= wval;
            ebtcr_pkg::ADDR_PORT7_LATCH: latch7_r <= wval;
            default:                     latch3_r <= latch3_r;
         endcase
      end
   end

   // sticky match flags, write one to clear, set wins
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         stat_r   <= 3'h0;
         irq_en_r <= 3'h0;
      end
      else if (clk_en_in)
      begin
         if (wr_any && reg_addr_in == ebtcr_pkg::ADDR_IRQ_STAT)
            stat_r <= (stat_r & ~stat_clr[2:0]) | match_evt;
         else
            stat_r <= stat_r | match_evt;
         if (wr_any && reg_addr_in == ebtcr_pkg::ADDR_IRQ_EN)
            irq_en_r <= wval[2:0];
      end
   end

   assign irq_out = |(stat_r & irq_en_r);

   // read data valid in the cycle after the strobe only
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         rdata_r <= 8'h00;
      else if (clk_en_in)
         rdata_r <= reg_rd_in ? rd_mux : 8'h00;
   end

   assign reg_rdata_out = rdata_r;

   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         ev_d_r <= 3'h0;
      else if (clk_en_in)
         ev_d_r <= event_input_in;
   end

   for (genvar i = 0; i < ebtcr_pkg::NUM_CH; i++)
   begin : g_ch
      logic [3:0]  shamt;
      logic [10:0] pre_mask;
      logic [1:0]  preset;

      assign shamt    = {tcl_r[i] - ebtcr_pkg::SEL_LADDER_BASE, 1'b0} +
                        ((i == ebtcr_pkg::CH_ODD_LADDER) ? ebtcr_pkg::LADDER_ODD_CH2 : 4'h0);
      assign pre_mask = 11'((12'h001 << shamt) - 12'h001);
      assign preset   = wval[ebtcr_pkg::TMC_PRESET_HI_BIT:ebtcr_pkg::TMC_PRESET_LO_BIT];

      always_comb
      begin
         case (tcl_r[i])
            ebtcr_pkg::SEL_EV_FALL: tick[i] = run_r[i] & ev_d_r[i] & ~event_input_in[i];
            ebtcr_pkg::SEL_EV_RISE: tick[i] = run_r[i] & ~ev_d_r[i] & event_input_in[i];
            default:                tick[i] = run_r[i] & (&(pre_r[i] | ~pre_mask));
         endcase
      end

      assign match_evt[i] = tick[i] & ~pwm_r[i] & (cnt_r[i] == cmp_r[i]);

      always_ff @(posedge ref_clk_in)
      begin
         if (sys_rst_in)
            pre_r[i] <= 11'h000;
         else if (clk_en_in)
            pre_r[i] <= run_r[i] ? pre_r[i] + 11'h001 : 11'h000;
      end

      always_ff @(posedge ref_clk_in)
      begin
         if (sys_rst_in)
         begin
            cnt_r[i] <= 8'h00;
            act_r[i] <= 1'b0;
         end
         else if (clk_en_in)
         begin
            if (!run_r[i])
            begin
               cnt_r[i] <= 8'h00;
               act_r[i] <= 1'b0;
            end
            else if (tick[i])
            begin
               cnt_r[i] <= match_evt[i] ? 8'h00 : cnt_r[i] + 8'h01;
               if (cnt_r[i] == cmp_r[i])
                  act_r[i] <= 1'b0;
               else if (cnt_r[i] == ebtcr_pkg::CNT_TOP)
                  act_r[i] <= 1'b1;
            end
         end
      end

      always_ff @(posedge ref_clk_in)
      begin
         if (sys_rst_in)
            ff_r[i] <= 1'b0;
         else if (clk_en_in)
         begin
            if (tmc_wr[i] && preset == ebtcr_pkg::PRESET_LOW)
               ff_r[i] <= 1'b0;
            else if (tmc_wr[i] && preset == ebtcr_pkg::PRESET_HIGH)
               ff_r[i] <= 1'b1;
            else if (match_evt[i] && pol_r[i])
               ff_r[i] <= ~ff_r[i];
         end
      end

      assign tout[i] = pwm_r[i] ? ((run_r[i] & act_r[i]) ^ pol_r[i]) : ff_r[i];
   end

   assign timer_output_out = tout;

   always_comb
   begin
      port3_pin_out = latch3_r;
      port7_pin_out = latch7_r;
      port3_pin_out[ebtcr_pkg::TOUT0_PORT3_BIT] = latch3_r[ebtcr_pkg::TOUT0_PORT3_BIT] | (oe_r[0] & tout[0]);
      port3_pin_out[ebtcr_pkg::TOUT1_PORT3_BIT] = latch3_r[ebtcr_pkg::TOUT1_PORT3_BIT] | (oe_r[1] & tout[1]);
      port7_pin_out[ebtcr_pkg::TOUT2_PORT7_BIT] = latch7_r[ebtcr_pkg::TOUT2_PORT7_BIT] | (oe_r[2] & tout[2]);
   end

   assign port3_pin_oe_out = ~dir3_r;
   assign port7_pin_oe_out = ~dir7_r;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   property p_reset_defaults;
      disable iff (1'b0)
      sys_rst_in |=> (run_r == 3'h0 && pwm_r == 3'h0 && tcl_r[0] == 3'h0 && tcl_r[2] == 3'h0 &&
                      dir3_r == 8'hFF && dir7_r == 8'hFF);
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("registers not at reset values");

   property p_stop_clears;
      clk_en_in && !run_r[0] && !tmc_wr[0] |=> cnt_r[0] == 8'h00 && pre_r[0] == 11'h000;
   endproperty
   a_stop_clears: assert property (p_stop_clears) else $error("stopped channel kept count");

   property p_match_restart;
      clk_en_in && match_evt[1] |=> cnt_r[1] == 8'h00 && stat_r[1];
   endproperty
   a_match_restart: assert property (p_match_restart) else $error("match did not restart or flag");

   property p_toggle;
      clk_en_in && match_evt[0] && pol_r[0] && !tmc_wr[0] |=> ff_r[0] != $past(ff_r[0]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("output flip-flop did not toggle");

   property p_pwm_idle;
      pwm_r[2] && !run_r[2] |-> timer_output_out[2] == pol_r[2];
   endproperty
   a_pwm_idle: assert property (p_pwm_idle) else $error("stopped PWM output not inactive");

   property p_preset_reads_zero;
      clk_en_in && reg_rd_in && reg_addr_in == ebtcr_pkg::ADDR_TMC1 |=> reg_rdata_out[3:2] == 2'h0;
   endproperty
   a_preset_reads_zero: assert property (p_preset_reads_zero) else $error("preset bits read nonzero");

   property p_dir_gates_pin;
      port3_pin_oe_out[3] == !dir3_r[3] && port7_pin_oe_out[2] == !dir7_r[2];
   endproperty
   a_dir_gates_pin: assert property (p_dir_gates_pin) else $error("pin enable disagrees with direction");

   property p_oe_off_port_mode;
      !oe_r[1] |-> port3_pin_out[4] == latch3_r[4];
   endproperty
   a_oe_off_port_mode: assert property (p_oe_off_port_mode) else $error("disabled timer reached the pin");

   property p_ch2_half_rate;
      run_r[2] && tcl_r[2] == 3'h2 && tick[2] && clk_en_in |=> !clk_en_in || !tick[2];
   endproperty
   a_ch2_half_rate: assert property (p_ch2_half_rate) else $error("channel 2 fastest tick not halved");

   property p_ch0_full_rate;
      run_r[0] && tcl_r[0] == 3'h2 |-> tick[0];
   endproperty
   a_ch0_full_rate: assert property (p_ch0_full_rate) else $error("channel 0 fx tick missing");

   property p_bit_write;
      clk_en_in && reg_bit_wr_in && reg_addr_in == ebtcr_pkg::ADDR_TMC1 && reg_bit_sel_in == 3'h0
      |=> oe_r[1] == $past(reg_wdata_in[0]);
   endproperty
   a_bit_write: assert property (p_bit_write) else $error("bit write missed output enable");

   property p_cov_match;
      match_evt[0];
   endproperty
   c_cov_match: cover property (p_cov_match);

   property p_cov_pwm_active;
      pwm_r[1] && run_r[1] && act_r[1];
   endproperty
   c_cov_pwm_active: cover property (p_cov_pwm_active);

   property p_cov_irq;
      irq_out;
   endproperty
   c_cov_irq: cover property (p_cov_irq);

endmodule : ebtcr_core
`default_nettype wire

// File: bench/ebtcr_tb_top.sv
// self-checking testbench for the three-channel 8-bit timer control registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end
module ebtcr_tb_top;
   logic        ref_clk_in     = 1'b0;
   logic        sys_rst_in     = 1'b1;
   logic        clk_en_in      = 1'b1;
   logic [15:0] reg_addr_in    = 16'h0000;
   logic [7:0]  reg_wdata_in   = 8'h00;
   logic        reg_wr_in      = 1'b0;
   logic        reg_bit_wr_in  = 1'b0;
   logic [2:0]  reg_bit_sel_in = 3'h0;
   logic        reg_rd_in      = 1'b0;
   logic [2:0]  event_input_in = 3'h0;
   logic [7:0]  reg_rdata_out;
   logic [2:0]  timer_output_out;
   logic [7:0]  port3_pin_out;
   logic [7:0]  port3_pin_oe_out;
   logic [7:0]  port7_pin_out;
   logic [7:0]  port7_pin_oe_out;
   logic        irq_out;
   logic        rd_seen_r      = 1'b0;
   logic [7:0]  lfsr_r         = 8'h49;
   logic [7:0]  exp_q[$];
   logic [7:0]  r;
   logic [7:0]  exp_v;
   logic [15:0] tmc_a;
   logic [15:0] tcl_a;
   logic        v;
   int          error_cnt      = 0;
   int          compares       = 0;
   int          s;
   int          c;
   int          n;
   int          hi;

   ebtcr_core uut
   (
      .ref_clk_in       (ref_clk_in),
      .sys_rst_in       (sys_rst_in),
      .clk_en_in        (clk_en_in),
      .reg_addr_in      (reg_addr_in),
      .reg_wdata_in     (reg_wdata_in),
      .reg_wr_in        (reg_wr_in),
      .reg_bit_wr_in    (reg_bit_wr_in),
      .reg_bit_sel_in   (reg_bit_sel_in),
      .reg_rd_in        (reg_rd_in),
      .reg_rdata_out    (reg_rdata_out),
      .event_input_in   (event_input_in),
      .timer_output_out (timer_output_out),
      .port3_pin_out    (port3_pin_out),
      .port3_pin_oe_out (port3_pin_oe_out),
      .port7_pin_out    (port7_pin_out),
      .port7_pin_oe_out (port7_pin_oe_out),
      .irq_out          (irq_out)
   );

   always #20 ref_clk_in = ~ref_clk_in;

   // read answers stand one cycle after the strobe
   always @(posedge ref_clk_in) rd_seen_r <= reg_rd_in;
   always @(negedge ref_clk_in)
      if (rd_seen_r)
      begin
         exp_v = exp_q.pop_front();
         `CHK(reg_rdata_out, exp_v)
      end

   function automatic logic [7:0] lfsr_next();
      lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      return lfsr_r;
   endfunction : lfsr_next

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in    <= 1'b0;
   endtask : wr

   task automatic bwr(input logic [15:0] a, input logic [2:0] b, input logic d);
      @(posedge ref_clk_in);
      reg_addr_in    <= a;
      reg_bit_sel_in <= b;
      reg_wdata_in   <= {7'h00, d};
      reg_bit_wr_in  <= 1'b1;
      @(posedge ref_clk_in);
      reg_bit_wr_in  <= 1'b0;
   endtask : bwr

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in   <= 1'b0;
   endtask : rd_chk

   task automatic settle(input int k);
      repeat (k) @(negedge ref_clk_in);
   endtask : settle

   // cycles between two successive changes of one channel output
   task automatic meas(input int ch, output int cnt);
      logic lv;
      int   t;
      settle(1);
      lv = timer_output_out[ch];
      t = 0;
      while (timer_output_out[ch] === lv && t < 5000)
      begin
         settle(1);
         t++;
      end
      lv = timer_output_out[ch];
      cnt = 0;
      while (timer_output_out[ch] === lv && cnt < 5000)
      begin
         settle(1);
         cnt++;
      end
   endtask : meas

   task automatic done(input string name);
      settle(3);
      $display("test %s done", name);
   endtask : done

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (40000) @(posedge ref_clk_in);
      error_cnt++;
      tally_and_finish();
   end

   initial
   begin
      repeat (2) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      rd_chk(ebtcr_pkg::ADDR_TMC0, 8'h00);
      rd_chk(ebtcr_pkg::ADDR_TMC1, 8'h00);
      rd_chk(ebtcr_pkg::ADDR_TMC2, 8'h00);
      rd_chk(ebtcr_pkg::ADDR_TCL0, 8'h00);
      rd_chk(ebtcr_pkg::ADDR_TCL1, 8'h00);
      rd_chk(ebtcr_pkg::ADDR_TCL2, 8'h00);
      rd_chk(ebtcr_pkg::ADDR_PORT3_DIR, 8'hFF);
      rd_chk(ebtcr_pkg::ADDR_PORT7_DIR, 8'hFF);
      rd_chk(16'hFF00, 8'h00);
      `CHK({port3_pin_oe_out, port7_pin_oe_out}, 16'h0000)
      done("reset");
      for (s = 0; s < 4; s++)
      begin
         r = lfsr_next();
         wr(ebtcr_pkg::ADDR_PORT7_DIR, r);
         rd_chk(ebtcr_pkg::ADDR_PORT7_DIR, r | ebtcr_pkg::PORT7_FIXED_ONES);
         `CHK(port7_pin_oe_out, ~(r | ebtcr_pkg::PORT7_FIXED_ONES))
         r = lfsr_next();
         wr(ebtcr_pkg::ADDR_TMC2, r);
         rd_chk(ebtcr_pkg::ADDR_TMC2, r & 8'hC3);
         r = lfsr_next();
         wr(ebtcr_pkg::ADDR_CMP1, r);
         rd_chk(ebtcr_pkg::ADDR_CMP1, r);
      end
      clk_en_in <= 1'b0;
      wr(ebtcr_pkg::ADDR_CMP1, 8'h5A);
      clk_en_in <= 1'b1;
      rd_chk(ebtcr_pkg::ADDR_CMP1, r);
      wr(ebtcr_pkg::ADDR_TMC2, 8'h00);
      wr(ebtcr_pkg::ADDR_CMP1, 8'h00);
      bwr(ebtcr_pkg::ADDR_TMC1, 3'h0, 1'b1);
      bwr(ebtcr_pkg::ADDR_TMC1, 3'h7, 1'b1);
      rd_chk(ebtcr_pkg::ADDR_TMC1, 8'h81);
      wr(ebtcr_pkg::ADDR_TMC1, 8'h00);
      bwr(ebtcr_pkg::ADDR_TMC1, 3'h3, 1'b1);
      settle(2);
      `CHK(timer_output_out[1], 1'b1)
      rd_chk(ebtcr_pkg::ADDR_TMC1, 8'h00);
      done("register access");
      wr(ebtcr_pkg::ADDR_PORT3_LATCH, 8'h00);
      wr(ebtcr_pkg::ADDR_PORT3_DIR, 8'hF7);
      settle(1);
      `CHK(port3_pin_oe_out, 8'h08)
      wr(ebtcr_pkg::ADDR_TMC0, 8'h09);
      settle(2);
      `CHK({timer_output_out[0], port3_pin_out[3]}, 2'h3)
      wr(ebtcr_pkg::ADDR_TMC0, 8'h05);
      settle(2);
      `CHK({timer_output_out[0], port3_pin_out[3]}, 2'h0)
      wr(ebtcr_pkg::ADDR_TMC0, 8'h0D);
      settle(2);
      `CHK(timer_output_out[0], 1'b0)
      wr(ebtcr_pkg::ADDR_TMC0, 8'h08);
      settle(2);
      `CHK({timer_output_out[0], port3_pin_out[3]}, 2'h2)
      done("preset and enable");
      wr(ebtcr_pkg::ADDR_TCL0, 8'h02);
      wr(ebtcr_pkg::ADDR_TMC0, 8'h80);
      v = timer_output_out[0];
      settle(20);
      `CHK(timer_output_out[0], v)
      wr(ebtcr_pkg::ADDR_TMC0, 8'h00);
      wr(ebtcr_pkg::ADDR_CMP0, 8'h03);
      wr(ebtcr_pkg::ADDR_IRQ_STAT, 8'h01);
      wr(ebtcr_pkg::ADDR_IRQ_EN, 8'h01);
      wr(ebtcr_pkg::ADDR_TMC0, 8'h82);
      settle(8);
      `CHK(irq_out, 1'b1)
      meas(0, n);
      `CHK(n, 4)
      wr(ebtcr_pkg::ADDR_IRQ_EN, 8'h00);
      settle(1);
      `CHK(irq_out, 1'b0)
      rd_chk(ebtcr_pkg::ADDR_IRQ_STAT, 8'h01);
      wr(ebtcr_pkg::ADDR_TMC0, 8'h00);
      rd_chk(ebtcr_pkg::ADDR_CNT0, 8'h00);
      wr(ebtcr_pkg::ADDR_IRQ_STAT, 8'h01);
      rd_chk(ebtcr_pkg::ADDR_IRQ_STAT, 8'h00);
      done("interval and interrupt");
      for (s = 2; s < 8; s++)
         for (c = 1; c < 3; c++)
         begin
            tmc_a = (c == 1) ? ebtcr_pkg::ADDR_TMC1 : ebtcr_pkg::ADDR_TMC2;
            tcl_a = (c == 1) ? ebtcr_pkg::ADDR_TCL1 : ebtcr_pkg::ADDR_TCL2;
            wr(tcl_a, s[7:0]);
            wr(tmc_a, 8'h82);
            meas(c, n);
            `CHK(n, (c == 1) ? (1 << (2 * (s - 2))) : (2 << (2 * (s - 2))))
            wr(tmc_a, 8'h00);
         end
      done("prescaler ladder");
      for (s = 0; s < 2; s++)
      begin
         wr(ebtcr_pkg::ADDR_TCL2, s[7:0]);
         wr(ebtcr_pkg::ADDR_TMC2, 8'h83);
         for (c = 0; c < 2; c++)
         begin
            settle(1);
            v = timer_output_out[2];
            @(posedge ref_clk_in);
            event_input_in[2] <= (c == 0);
            settle(3);
            `CHK({timer_output_out[2], port7_pin_out[2]}, {2{v ^ ((c == 0) == (s == 1))}})
         end
         wr(ebtcr_pkg::ADDR_TMC2, 8'h00);
      end
      done("event edges");
      wr(ebtcr_pkg::ADDR_IRQ_STAT, 8'h07);
      wr(ebtcr_pkg::ADDR_TCL1, 8'h02);
      wr(ebtcr_pkg::ADDR_CMP1, 8'h10);
      for (s = 0; s < 2; s++)
      begin
         wr(ebtcr_pkg::ADDR_TMC1, (s == 0) ? 8'hC1 : 8'hC3);
         settle(300);
         hi = 0;
         repeat (512)
         begin
            settle(1);
            hi += (timer_output_out[1] === 1'b1);
         end
         `CHK(hi, (s == 0) ? 34 : 478)
      end
      rd_chk(ebtcr_pkg::ADDR_IRQ_STAT, 8'h00);
      wr(ebtcr_pkg::ADDR_TMC1, 8'h43);
      settle(3);
      `CHK(timer_output_out[1], 1'b1)
      done("pwm");
      tally_and_finish();
   end
endmodule : ebtcr_tb_top
`default_nettype wire
